// file: rtl/timer_event_pkg.sv
// -----------------------------------------------------------------
// Shared constants and types of the 8-bit timer/event counter
// -----------------------------------------------------------------
package timer_event_pkg;

  // Counter and compare width, and divider width
  localparam int COUNT_WIDTH = 8;
  localparam int PRESCALE_WIDTH = 10;

  // Counter landmarks
  localparam logic [7:0] COUNT_ZERO = 8'h00;
  localparam logic [7:0] COUNT_ONE  = 8'h01;
  localparam logic [7:0] COUNT_MAX  = 8'hff;

  // Clock select codes for the event input edges
  localparam logic [2:0] CLKSEL_FALL = 3'h0;
  localparam logic [2:0] CLKSEL_RISE = 3'h1;
  localparam logic [2:0] CLKSEL_RESET = 3'h0;

  // Mode control register, bit 7 down to bit 0
  typedef struct packed {
    logic       countEnable;      // Bit 7
    logic       pwmMode;          // Bit 6
    logic [1:0] reserved;         // Bits 5:4, read as zero
    logic       flipflopSet;      // Bit 3, write-only
    logic       flipflopClear;    // Bit 2, write-only
    logic       invertOrPolarity; // Bit 1
    logic       outputEnable;     // Bit 0
  } mode_s;

  localparam logic [7:0] MODE_RESET = 8'h00;

  // Whole state of the counter block
  typedef struct packed {
    mode_s      mode;          // Mode control register
    logic [7:0] count;         // Count value
    logic [7:0] compareRead;   // Compare value as software sees it
    logic [7:0] compareActive; // Compare value used for matching
    logic [2:0] clockSel;      // Count clock source
    logic       outFf;         // Timer output flip-flop
    logic       pwmOn;         // PWM pulse in its active phase
    logic       matchPulse;    // Match interrupt pulse
    logic       timerOut;      // Timer output pin level
  } timer_state_s;

  localparam timer_state_s TIMER_STATE_RESET = '0;

  // State of the count tick generator
  typedef struct packed {
    logic       sync1;    // First synchroniser stage
    logic       sync2;    // Second synchroniser stage
    logic       sync3;    // Delayed copy for edge detection
    logic [9:0] prescale; // Free-running divider
    logic       tick;     // Count tick
  } tick_state_s;

  localparam tick_state_s TICK_STATE_RESET = '0;

  // Divider mask per internal clock select code
  function automatic logic [9:0] prescale_mask(input logic [2:0] sel);
    case (sel)
      3'h2:    prescale_mask = 10'h000;
      3'h3:    prescale_mask = 10'h003;
      3'h4:    prescale_mask = 10'h00f;
      3'h5:    prescale_mask = 10'h03f;
      3'h6:    prescale_mask = 10'h0ff;
      default: prescale_mask = 10'h3ff;
    endcase
  endfunction

endpackage

// file: rtl/count_tick_gen.sv
`timescale 1ns/10ps
`default_nettype none
module count_tick_gen
  import timer_event_pkg::*;
(
  input  wire logic       clock,
  input  wire logic       srst,
  input  wire logic       eventPin,
  input  wire logic [2:0] clockSel,
  output var  logic       countTick
);

  // -----------------------------------------------------------------
  // State
  // -----------------------------------------------------------------
  tick_state_s state_q;   // Registered state
  tick_state_s state_d;   // Next state
  logic        riseEdge;  // Rising edge on synced event input
  logic        fallEdge;  // Falling edge on synced event input
  logic [9:0]  mask;      // Divider mask for the chosen rate

  // -----------------------------------------------------------------
  // Next state
  // -----------------------------------------------------------------
  // Edges are taken from the second and third stages only
  always_comb begin
    state_d = state_q;
    state_d.sync1 = eventPin;
    state_d.sync2 = state_q.sync1;
    state_d.sync3 = state_q.sync2;
    // Divider runs free, so a start is not aligned to it
    state_d.prescale = state_q.prescale + 10'h001;
    riseEdge = state_q.sync2 & ~state_q.sync3;
    fallEdge = ~state_q.sync2 & state_q.sync3;
    mask = prescale_mask(clockSel);
    case (clockSel)
      // Event counting on the chosen edge
      CLKSEL_FALL: state_d.tick = fallEdge;
      CLKSEL_RISE: state_d.tick = riseEdge;
      // Internal divided clock
      default:     state_d.tick = ((state_q.prescale & mask) == mask);
    endcase
  end

  // -----------------------------------------------------------------
  // Registers
  // -----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (srst) begin
      state_q <= TICK_STATE_RESET;
    end else begin
      state_q <= state_d;
    end
  end

  assign countTick = state_q.tick;

endmodule
`default_nettype wire

// file: rtl/timer_event_counter_8bit.sv
// What this block does
// - Clear mode: match clears count, raises interrupt
// - Count enable bit starts and stops counting
// - Event mode counts chosen event pin edge
// - Inversion enabled: match toggles output flip-flop
// - Square period is two times compare plus two
// - Set or clear bit presets output level
// - Mode bit six selects PWM operation
// - Bit one selects PWM active level
// - Bit zero gates waveform onto output pin
// - PWM active from overflow until compare match
// - PWM period 256 ticks, width N ticks
// - Stopping in PWM forces inactive level
// - PWM compare write buffered until next overflow
// - Compare read returns new value while pending
// - Start may deviate one count clock
// - Three-bit field picks the count clock
// - Mode bit free-runs PWM, else clear-start
// - Set and clear bits read back zero
`timescale 1ns/10ps
`default_nettype none
module timer_event_counter_8bit
  import timer_event_pkg::*;
(
  input  wire logic       clock,
  input  wire logic       srst,
  input  wire logic       eventPin,
  input  wire logic       modeWrite,
  input  wire mode_s      modeWdata,
  input  wire logic       compareWrite,
  input  wire logic [7:0] compareWdata,
  input  wire logic       clockSelWrite,
  input  wire logic [2:0] clockSelWdata,
  output var  mode_s      modeReadback,
  output var  logic [7:0] compareReadback,
  output var  logic [2:0] clockSelReadback,
  output var  logic [7:0] countValue,
  output var  logic       matchInterrupt,
  output var  logic       timerOutputPin
);

  // -----------------------------------------------------------------
  // Declarations
  // -----------------------------------------------------------------
  timer_state_s state_q;    // Registered state
  timer_state_s state_d;    // Next state
  logic         countTick;  // One count clock has passed
  logic [7:0]   nextCount;  // Count plus one, wraps at the top
  logic         isMatch;    // Count equals active compare
  logic         isOverflow; // Count sits at its top value
  logic         pwmRunning; // Counting in PWM mode

  // -----------------------------------------------------------------
  // Count clock source
  // -----------------------------------------------------------------
  // Picks event edges or a divided clock, synced and registered
  count_tick_gen tick_gen (
    .clock     (clock),
    .srst      (srst),
    .eventPin  (eventPin),
    .clockSel  (state_q.clockSel),
    .countTick (countTick)
  );

  // -----------------------------------------------------------------
  // Next state
  // -----------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    state_d.matchPulse = 1'b0;
    nextCount = state_q.count + COUNT_ONE;
    isMatch = (state_q.count == state_q.compareActive);
    isOverflow = (state_q.count == COUNT_MAX);
    pwmRunning = state_q.mode.pwmMode & state_q.mode.countEnable;

    // Counter
    if (!state_q.mode.countEnable) begin
      // Stopped: hold count at zero, PWM back to idle
      state_d.count = COUNT_ZERO;
      state_d.pwmOn = 1'b0;
    end else if (countTick) begin
      if (state_q.mode.pwmMode) begin
        // Free-running, match does not clear
        state_d.count = nextCount;
        if (isMatch) begin
          state_d.matchPulse = 1'b1;
        end
        if (isOverflow) begin
          // Pending compare moves in at overflow
          state_d.compareActive = state_q.compareRead;
          // Active phase starts, none for a zero width
          state_d.pwmOn = (state_q.compareRead != COUNT_ZERO);
        end else if (nextCount == state_q.compareActive) begin
          // Width reached, inactive until next overflow
          state_d.pwmOn = 1'b0;
        end
      end else begin
        if (isMatch) begin
          // Period of compare plus one ticks
          state_d.count = COUNT_ZERO;
          state_d.matchPulse = 1'b1;
          if (state_q.mode.invertOrPolarity) begin
            state_d.outFf = ~state_q.outFf;
          end
        end else begin
          state_d.count = nextCount;
        end
      end
    end

    // Compare register write
    if (compareWrite) begin
      // Readback always shows the newest write
      state_d.compareRead = compareWdata;
      if (!pwmRunning) begin
        state_d.compareActive = compareWdata;
      end
    end

    // Mode register write
    if (modeWrite) begin
      state_d.mode = modeWdata;
      state_d.mode.reserved = 2'h0;
      // Preset bits act once and are not stored
      state_d.mode.flipflopSet = 1'b0;
      state_d.mode.flipflopClear = 1'b0;
      if (!modeWdata.pwmMode &&
          (modeWdata.flipflopSet != modeWdata.flipflopClear)) begin
        state_d.outFf = modeWdata.flipflopSet;
      end
      // Stop drops the PWM phase in the same cycle as the write
      if (!modeWdata.countEnable) begin
        state_d.pwmOn = 1'b0;
      end
    end

    // Clock select register write
    if (clockSelWrite) begin
      state_d.clockSel = clockSelWdata;
    end

    // Output pin level, low when disabled
    if (!state_d.mode.outputEnable) begin
      state_d.timerOut = 1'b0;
    end else if (state_d.mode.pwmMode) begin
      state_d.timerOut = state_d.pwmOn ^ state_d.mode.invertOrPolarity;
    end else begin
      state_d.timerOut = state_d.outFf;
    end
  end

  // -----------------------------------------------------------------
  // Registers
  // -----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (srst) begin
      state_q <= TIMER_STATE_RESET;
    end else begin
      state_q <= state_d;
    end
  end

  // -----------------------------------------------------------------
  // Outputs
  // -----------------------------------------------------------------
  assign modeReadback     = state_q.mode;
  assign compareReadback  = state_q.compareRead;
  assign clockSelReadback = state_q.clockSel;
  assign countValue       = state_q.count;
  assign matchInterrupt   = state_q.matchPulse;
  assign timerOutputPin   = state_q.timerOut;

  // -----------------------------------------------------------------
  // Checks
  // -----------------------------------------------------------------
  // Clear mode match restarts count and pulses interrupt
  a_clear_on_match:
  assert property (@(posedge clock) disable iff (srst)
    (state_q.mode.countEnable && !state_q.mode.pwmMode && countTick &&
     isMatch && !modeWrite)
    |=> (state_q.count == COUNT_ZERO) && matchInterrupt)
  else $error("clear mode match did not restart count");

  // Stopped counter reads zero next cycle
  a_stop_clears_count:
  assert property (@(posedge clock) disable iff (srst)
    !state_q.mode.countEnable |=> (state_q.count == COUNT_ZERO))
  else $error("stopped counter not cleared");

  // Without a tick the running count holds
  a_count_holds:
  assert property (@(posedge clock) disable iff (srst)
    (state_q.mode.countEnable && !countTick && !modeWrite)
    |=> $stable(state_q.count))
  else $error("count moved without a tick");

  // Inverting match flips the pin in square-wave use
  a_square_toggle:
  assert property (@(posedge clock) disable iff (srst)
    (state_q.mode == 8'h83 && countTick && isMatch && !modeWrite)
    |=> (timerOutputPin != $past(timerOutputPin)))
  else $error("square wave did not toggle on match");

  // Preset bits reach the pin when output enabled
  a_preset_level:
  assert property (@(posedge clock) disable iff (srst)
    (modeWrite && !modeWdata.pwmMode && modeWdata.outputEnable &&
     modeWdata.flipflopSet != modeWdata.flipflopClear)
    |=> (timerOutputPin == $past(modeWdata.flipflopSet)))
  else $error("preset level not on pin");

  // Disabled output stays low
  a_output_gated:
  assert property (@(posedge clock) disable iff (srst)
    !state_q.mode.outputEnable |-> !timerOutputPin)
  else $error("pin high with output disabled");

  // Overflow with nonzero compare enters active phase
  a_pwm_overflow:
  assert property (@(posedge clock) disable iff (srst)
    (pwmRunning && countTick && isOverflow && !modeWrite &&
     state_q.compareRead != COUNT_ZERO)
    |=> state_q.pwmOn &&
        (timerOutputPin == !state_q.mode.invertOrPolarity ||
         !state_q.mode.outputEnable))
  else $error("PWM not active after overflow");

  // Reaching the width ends the active phase
  a_pwm_width_end:
  assert property (@(posedge clock) disable iff (srst)
    (pwmRunning && countTick && !isOverflow && !modeWrite &&
     nextCount == state_q.compareActive)
    |=> !state_q.pwmOn)
  else $error("PWM active past its width");

  // Stopping PWM drives inactive level
  a_pwm_stop_idle:
  assert property (@(posedge clock) disable iff (srst)
    ($fell(state_q.mode.countEnable) && state_q.mode.pwmMode &&
     state_q.mode.outputEnable)
    |-> (timerOutputPin == state_q.mode.invertOrPolarity))
  else $error("PWM pin not inactive after stop");

  // Running PWM write shows at once but matches later
  a_pwm_buffered:
  assert property (@(posedge clock) disable iff (srst)
    (pwmRunning && compareWrite && !modeWrite &&
     !(countTick && isOverflow))
    |=> $stable(state_q.compareActive) &&
        (compareReadback == $past(compareWdata)))
  else $error("PWM compare not buffered");

  // Write-only bits always read zero
  a_preset_readzero:
  assert property (@(posedge clock) disable iff (srst)
    !modeReadback.flipflopSet && !modeReadback.flipflopClear)
  else $error("preset bits read back nonzero");

  // PWM match never clears the counter
  a_pwm_no_clear:
  assert property (@(posedge clock) disable iff (srst)
    (pwmRunning && countTick && isMatch && !isOverflow && !modeWrite)
    |=> (state_q.count == $past(nextCount)))
  else $error("PWM match cleared the count");

  // Outside PWM the enabled pin shows the flip-flop
  a_pin_follows_ff:
  assert property (@(posedge clock) disable iff (srst)
    (!state_q.mode.pwmMode && state_q.mode.outputEnable)
    |-> (timerOutputPin == state_q.outFf))
  else $error("pin does not follow output flip-flop");

  // In PWM the polarity bit picks the active level
  a_pwm_level_select:
  assert property (@(posedge clock) disable iff (srst)
    (state_q.mode.pwmMode && state_q.mode.outputEnable)
    |-> (timerOutputPin == (state_q.pwmOn ^ state_q.mode.invertOrPolarity)))
  else $error("PWM pin level does not match polarity");

  // Overflow wraps the running PWM count to zero
  a_overflow_wraps:
  assert property (@(posedge clock) disable iff (srst)
    (pwmRunning && countTick && isOverflow && !modeWrite)
    |=> (state_q.count == COUNT_ZERO))
  else $error("PWM overflow did not wrap the count");

  // Pending compare moves into use at overflow
  a_pwm_compare_load:
  assert property (@(posedge clock) disable iff (srst)
    (pwmRunning && countTick && isOverflow && !modeWrite)
    |=> (state_q.compareActive == $past(state_q.compareRead)))
  else $error("pending compare not loaded at overflow");

  // Clock select write shows on readback next cycle
  a_clock_select_load:
  assert property (@(posedge clock) disable iff (srst)
    clockSelWrite |=> (clockSelReadback == $past(clockSelWdata)))
  else $error("clock select write not taken");

endmodule
`default_nettype wire

// file: tb/event_source.sv
`timescale 1ns/10ps
`default_nettype none
module event_source (
  input  wire logic clock,
  output var  logic pinOut
);
  // Line idles low between pulses
  initial pinOut = 1'b0;
  // ------------------------------------------
  // Pulse train
  // ------------------------------------------
  // Six clocks per level so each edge clears the synchroniser
  task automatic emit(input int n);
    for (int i = 0; i < n; i++) begin
      repeat (6) @(posedge clock);
      pinOut <= 1'b1;
      repeat (6) @(posedge clock);
      pinOut <= 1'b0;
    end
  endtask
endmodule
`default_nettype wire

// file: tb/timer_event_counter_8bit_test.sv
`timescale 1ns/10ps
`default_nettype none
module timer_event_counter_8bit_test
  import timer_event_pkg::*;
;
  logic        clock;           // Bench clock
  logic        srst;            // Synchronous reset
  wire logic   eventPin;        // Pulse line from the source
  logic        modeWrite;       // Mode strobe
  logic        compareWrite;    // Compare strobe
  logic        clockSelWrite;   // Clock select strobe
  logic [7:0]  modeWdata;       // Mode value
  logic [7:0]  compareWdata;    // Compare value
  logic [2:0]  clockSelWdata;   // Clock select value
  mode_s       modeReadback;    // Mode readback
  logic [7:0]  compareReadback; // Compare readback
  logic [2:0]  clockSelReadback;// Clock select readback
  logic [7:0]  countValue;      // Current count
  logic        matchInterrupt;  // Match pulse
  logic        timerOutputPin;  // Output pin
  int          errorCnt;        // Mismatches
  int          testsRun;        // Comparisons
  int          gap;             // Measured cycles
  int          hits;            // Measured level cycles
  logic [31:0] lfsrQ;           // Random state
  logic [7:0]  nVal;            // Chosen compare
  logic        lastPin;         // Pin at previous match

  // ------------------------------------------
  // Design and pulse source
  // ------------------------------------------
  timer_event_counter_8bit i_dut (
    .clock(clock), .srst(srst), .eventPin(eventPin),
    .modeWrite(modeWrite), .modeWdata(mode_s'(modeWdata)),
    .compareWrite(compareWrite), .compareWdata(compareWdata),
    .clockSelWrite(clockSelWrite), .clockSelWdata(clockSelWdata),
    .modeReadback(modeReadback), .compareReadback(compareReadback),
    .clockSelReadback(clockSelReadback), .countValue(countValue),
    .matchInterrupt(matchInterrupt), .timerOutputPin(timerOutputPin)
  );
  event_source i_src (.clock(clock), .pinOut(eventPin));

  // Clock of 50 ns period
  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end

  // ------------------------------------------
  // Helpers
  // ------------------------------------------
  // Next random word
  function automatic logic [31:0] lfsr_next(input logic [31:0] v);
    lfsr_next = {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  // Cycles between matches: compare plus one ticks of the chosen divider
  function automatic int exp_period(input int s, input int n);
    exp_period = (n + 1) << (2 * (s - 2));
  endfunction
  // Pass n edges and settle
  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  // Verdict and end of run
  task automatic wrapUp();
    if (errorCnt == 0 && testsRun > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Register write: 0 mode, 1 compare, 2 clock select
  task automatic wr(input int sel, input logic [7:0] v);
    @(posedge clock);
    modeWrite <= (sel == 0);
    compareWrite <= (sel == 1);
    clockSelWrite <= (sel == 2);
    modeWdata <= v;
    compareWdata <= v;
    clockSelWdata <= v[2:0];
    @(posedge clock);
    modeWrite <= 1'b0;
    compareWrite <= 1'b0;
    clockSelWrite <= 1'b0;
    #1;
  endtask
  // Compare of an 8-bit value
  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    testsRun++;
    if (got !== exp) begin
      errorCnt++;
      $display("FAIL %s expected %h seen %h", name, exp, got);
    end
  endtask
  // Compare of a measured count
  task automatic chk_int(input string name, input int exp, input int got);
    testsRun++;
    if (got != exp) begin
      errorCnt++;
      $display("FAIL %s expected %0d seen %0d", name, exp, got);
    end
  endtask
  // Cycles until the next match pulse, bounded
  task automatic wait_match(input int bound, output int n);
    n = 0;
    do begin
      cyc(1);
      n++;
    end while (matchInterrupt !== 1'b1 && n < bound);
    if (matchInterrupt !== 1'b1) begin
      errorCnt++;
      $display("FAIL match wait expected pulse seen none");
      wrapUp();
    end
  endtask
  // Cycles with the pin at a level within a window
  task automatic count_level(input int len, input logic lvl, output int n);
    n = 0;
    repeat (len) begin
      cyc(1);
      if (timerOutputPin === lvl) n++;
    end
  endtask

  // ------------------------------------------
  // Main sequence
  // ------------------------------------------
  initial begin
    srst = 1'b1;
    {modeWrite, compareWrite, clockSelWrite} = 3'h0;
    modeWdata = 8'h00;
    compareWdata = 8'h00;
    clockSelWdata = 3'h0;
    errorCnt = 0;
    testsRun = 0;
    lfsrQ = 32'h61f4;
    repeat (2) @(posedge clock);
    srst <= 1'b0;
    cyc(1);
    chk("count at reset", 8'h00, countValue);
    // Write-only and reserved bits read as zero
    wr(0, 8'h3f);
    cyc(1);
    chk("mode readback", 8'h03, modeReadback);
    // Every internal clock source with compare one
    wr(1, 8'h01);
    for (int s = 2; s < 8; s++) begin
      wr(0, 8'h00);
      wr(2, 8'(s));
      cyc(1);
      chk("clock select", 8'(s), {5'h0, clockSelReadback});
      wr(0, 8'h80);
      wait_match(3000, gap);
      wait_match(3000, gap);
      chk_int("match period", exp_period(s, 1), gap);
    end
    // Interval timer at the compare corners and at random
    for (int k = 0; k < 4; k++) begin
      lfsrQ = lfsr_next(lfsrQ);
      nVal = (k == 0) ? 8'h00 : (k == 1) ? 8'hff : lfsrQ[7:0];
      wr(0, 8'h00);
      wr(2, 8'h02);
      wr(1, nVal);
      wr(0, 8'h80);
      wait_match(300, gap);
      chk("count after match", 8'h00, countValue);
      wait_match(300, gap);
      chk_int("match period", exp_period(2, nVal), gap);
    end
    // Stopping clears and holds the count
    wr(0, 8'h00);
    cyc(6);
    chk("stopped count", 8'h00, countValue);
    // Square wave with preset levels
    lfsrQ = lfsr_next(lfsrQ);
    nVal = {4'h0, lfsrQ[3:0]};
    wr(1, nVal);
    wr(0, 8'h0b);
    cyc(1);
    chk("preset high", 8'h01, {7'h0, timerOutputPin});
    wr(0, 8'h07);
    cyc(1);
    chk("preset low", 8'h00, {7'h0, timerOutputPin});
    wr(0, 8'h83);
    wait_match(300, gap);
    lastPin = timerOutputPin;
    chk("first toggle", 8'h01, {7'h0, lastPin});
    count_level(2 * (nVal + 1), 1'b1, hits);
    chk_int("square high time", nVal + 1, hits);
    wait_match(300, gap);
    chk("second toggle", {7'h0, ~lastPin}, {7'h0, timerOutputPin});
    // Event counting on each edge kind
    for (int e = 0; e < 2; e++) begin
      wr(0, 8'h00);
      wr(2, 8'(e));
      wr(1, 8'hff);
      wr(0, 8'h80);
      lfsrQ = lfsr_next(lfsrQ);
      hits = 3 + lfsrQ[2:0];
      i_src.emit(hits);
      cyc(12);
      chk("event count", 8'(hits), countValue);
    end
    // Active-high PWM
    wr(0, 8'h00);
    wr(2, 8'h02);
    lfsrQ = lfsr_next(lfsrQ);
    nVal = lfsrQ[7:0];
    wr(1, nVal);
    wr(0, 8'h41);
    wr(0, 8'hc1);
    cyc(100);
    chk("pwm before overflow", 8'h00, {7'h0, timerOutputPin});
    cyc(200);
    count_level(256, 1'b1, hits);
    chk_int("pwm width", nVal, hits);
    wait_match(300, gap);
    wait_match(300, gap);
    chk_int("pwm period", 256, gap);
    // Compare rewrite during PWM
    nVal = lfsrQ[15:8];
    wr(1, nVal);
    cyc(1);
    chk("pending compare", nVal, compareReadback);
    cyc(600);
    count_level(256, 1'b1, hits);
    chk_int("new pwm width", nVal, hits);
    wr(0, 8'h41);
    chk("stop inactive", 8'h00, {7'h0, timerOutputPin});
    // Active-low PWM
    wr(0, 8'h43);
    cyc(1);
    chk("low idle", 8'h01, {7'h0, timerOutputPin});
    wr(0, 8'hc3);
    cyc(600);
    count_level(256, 1'b0, hits);
    chk_int("low width", nVal, hits);
    wr(0, 8'h43);
    cyc(1);
    chk("low stop", 8'h01, {7'h0, timerOutputPin});
    wr(0, 8'h42);
    cyc(1);
    chk("output off", 8'h00, {7'h0, timerOutputPin});
    wrapUp();
  end
endmodule
`default_nettype wire
